/* bench/or_and_move_instruction_exec_bench.sv */
// bench for the or/load/copy execution block
`timescale 1ns/1ns
`default_nettype none
module or_and_move_instruction_exec_bench;
  typedef struct packed {
    logic [7:0] acc;
    logic       zero;
    logic       ill;
  } note_t;
  logic        sys_clk;
  logic        sys_rst;
  logic [13:0] instr;
  logic [7:0]  accum_r;
  logic        zero_r;
  logic [1:0]  phase_r;
  logic        done_r;
  logic        illegal_r;
  note_t       notes[$];
  note_t       head;
  logic [7:0]  fileModel[128];
  logic [7:0]  accModel;
  logic        zeroModel;
  logic [15:0] rnd;
  logic [1:0]  lastPh;
  int          n_fail;
  int          n_checks;
  int          gap;
  bit          doneSeen;
  // ***************
  // design and clock
  // ***************
  or_and_move_instruction_exec u_or_and_move_instruction_exec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr),
    .accum_r(accum_r), .zero_r(zero_r), .phase_r(phase_r),
    .done_r(done_r), .illegal_r(illegal_r));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [1:0] nextPh(input logic [1:0] p);
    case (p)
      2'h0: return 2'h1;
      2'h1: return 2'h3;
      2'h3: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // drive one word, note the expected outcome, hold it four cycles
  task automatic op(input logic [13:0] w);
    logic [7:0] f;
    note_t n;
    f = fileModel[w[6:0]];
    n.ill = 1'b0;
    if (w[13:8] == 6'h04 || w[13:8] == 6'h08) begin
      f = (w[13:8] == 6'h04) ? (accModel | f) : f;
      zeroModel = (f == 8'h00);
      if (w[7]) fileModel[w[6:0]] = f;
      else accModel = f;
    end else if (w[13:10] == 4'hC) accModel = w[7:0];
    else n.ill = 1'b1;
    n.acc = accModel;
    n.zero = zeroModel;
    instr <= w;
    notes.push_back(n);
    repeat (4) @(posedge sys_clk);
  endtask
  // ***************
  // output watcher
  // ***************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      lastPh = 2'h2;
      doneSeen = 0;
    end else begin
      check("phase", {6'h00, nextPh(lastPh)}, {6'h00, phase_r});
      lastPh = phase_r;
      gap++;
      if (!done_r) check("idle illegal", 8'h00, {7'h00, illegal_r});
      if (done_r) begin
        if (doneSeen) check("done spacing", 8'h04, gap[7:0]);
        gap = 0;
        doneSeen = 1;
        if (notes.size() == 0) begin
          $display("unexpected done expected 0 seen 1");
          n_fail++;
        end else begin
          head = notes.pop_front();
          check("accum", head.acc, accum_r);
          check("zero", {7'h00, head.zero}, {7'h00, zero_r});
          check("illegal", {7'h00, head.ill}, {7'h00, illegal_r});
        end
      end
    end
  end
  // ***************
  // stimulus
  // ***************
  initial begin
    logic [6:0] a;
    sys_rst <= 1'b1;
    instr <= 14'h0000;
    n_fail = 0;
    n_checks = 0;
    gap = 0;
    rnd = 16'h2B11;
    accModel = 8'h00;
    zeroModel = 1'b0;
    foreach (fileModel[j]) fileModel[j] = 8'h00; // file memory starts clear
    repeat (5) @(posedge sys_clk);
    check("reset accum", 8'h00, accum_r);
    check("reset flags", 8'h00, {3'h0, zero_r, done_r, illegal_r, phase_r});
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      op({4'hC, k[1:0], rnd[7:0]});
    end
    op(14'h3300);
    // zero operand: flag set by copy to itself, kept by literal, then cleared
    op(14'h3000);
    op({6'h08, 1'b1, 7'h05});
    op(14'h3055);
    op({6'h04, 1'b0, 7'h05});
    op(14'h3000);
    op({6'h04, 1'b0, 7'h05});
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = rnd[6:0];
      op(14'h30FF);
      op({6'h04, 1'b1, a});
      rnd = lfsr(rnd);
      op({6'h30, rnd[7:0]});
      op({6'h08, 1'b0, a});
      rnd = lfsr(rnd);
      op({6'h30, rnd[7:0]});
      op({6'h08, 1'b1, a});
      op({6'h04, 1'b0, a});
    end
    op(14'h0000);
    op(14'h2ABC);
    op(14'h3800);
    for (int t = 0; t < 20 && notes.size() != 0; t++) @(posedge sys_clk);
    if (notes.size() != 0) begin
      $display("unexpected pending expected 0 seen %0d", notes.size());
      n_fail++;
    end
    print_verdict();
  end
endmodule // or_and_move_instruction_exec_bench
`default_nettype wire

/* rtl/exec_defines.svh */
// constants for the or/load/copy execution block
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
`define OP_OR_FILE    6'h04
`define OP_COPY_FILE  6'h08
`define OP_LIT_HI     2'h3
`define OP_LIT_SUB    2'h0
`define DEST_BIT      7
`define ACC_RESET     8'h00
`define ZERO_RESET    1'b0
`define FILE_DEPTH    128
`endif

/* rtl/exec_pkg.sv */
// types shared by the execution block
`include "exec_defines.svh"
package exec_pkg;
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b11,
    PH_WRITE   = 2'b10
  } phase_t;
  typedef enum logic [1:0] {
    OPK_NONE = 2'b00,
    OPK_OR   = 2'b01,
    OPK_LIT  = 2'b10,
    OPK_COPY = 2'b11
  } opkind_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic       wen;
  } file_req_t;
endpackage

/* rtl/file_mem.sv */
// file register memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module file_mem #(
  parameter int DEPTH = 128
) (
  input  wire logic       sys_clk,  // core clock
  input  wire logic [6:0] rdAddr,   // read address
  input  wire logic       wrEn,     // write strobe
  input  wire logic [6:0] wrAddr,   // write address
  input  wire logic [7:0] wrData,   // write data
  output logic      [7:0] rdData_r  // registered read data
);
  // cleared at power up so a zero operand is reachable
  logic [7:0] mem [DEPTH] = '{default: 8'h00};

  // write port
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read port
  always_ff @(posedge sys_clk) begin
    rdData_r <= mem[rdAddr];
  end
endmodule // file_mem
`default_nettype wire

/* rtl/or_and_move_instruction_exec.sv */
// execution of or-into-target, load-literal and copy-location
// How it works
// RL1: opcode 00 0100 ORs accumulator with file, result to destination.
// RL2: upper bits 11 00xx load low eight bits into accumulator.
// RL3: load literal leaves the zero flag alone; done still pulses.
// RL4: opcode 00 1000 copies; low seven bits address, bit 7 destination.
// RL5: copy writes the file value unchanged to its destination.
// RL6: destination bit 0 writes accumulator, 1 writes file register back.
// RL7: copy updates zero flag even when writing back to itself.
// RL8: four phases per instruction; zero set on zero result, else cleared.
`timescale 1ns/1ns
`default_nettype none
`include "exec_defines.svh"
module or_and_move_instruction_exec #(
  parameter int DEPTH = `FILE_DEPTH
) (
  input  wire logic        sys_clk,   // 25 MHz core clock
  input  wire logic        sys_rst,   // synchronous reset, high
  input  wire logic [13:0] instr,     // instruction word, held per cycle
  output logic      [7:0]  accum_r,   // accumulator
  output logic             zero_r,    // zero flag
  output logic      [1:0]  phase_r,   // current phase code
  output logic             done_r,    // pulse at end of instruction
  output logic             illegal_r  // pulse: word not handled here
);
  // ****************************************
  // phase sequencer
  // ****************************************
  exec_pkg::phase_t   phase_r_q, phase_nxt;
  exec_pkg::opkind_t  kind_r, kind_nxt;
  exec_pkg::file_req_t req;
  logic [13:0] ir_r;
  logic [7:0]  fileVal;
  logic [7:0]  result_r, result_nxt;

  // gray walk through four phases
  always_comb begin
    unique case (phase_r_q)
      exec_pkg::PH_DECODE:  phase_nxt = exec_pkg::PH_READ;
      exec_pkg::PH_READ:    phase_nxt = exec_pkg::PH_PROCESS;
      exec_pkg::PH_PROCESS: phase_nxt = exec_pkg::PH_WRITE;
      exec_pkg::PH_WRITE:   phase_nxt = exec_pkg::PH_DECODE;
    endcase
  end

  // phase register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r_q <= exec_pkg::PH_DECODE;
    end else begin
      phase_r_q <= phase_nxt; // RL8
    end
  end

  // ****************************************
  // decode
  // ****************************************
  // classify the incoming word
  always_comb begin
    kind_nxt = exec_pkg::OPK_NONE;
    if (instr[13:8] == `OP_OR_FILE) begin
      kind_nxt = exec_pkg::OPK_OR; // RL1
    end else if (instr[13:8] == `OP_COPY_FILE) begin
      kind_nxt = exec_pkg::OPK_COPY; // RL4
    end else if (instr[13:12] == `OP_LIT_HI &&
                 instr[11:10] == `OP_LIT_SUB) begin
      kind_nxt = exec_pkg::OPK_LIT; // RL2
    end
  end

  // latch word and kind in decode phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ir_r   <= 14'h0000;
      kind_r <= exec_pkg::OPK_NONE;
    end else if (phase_r_q == exec_pkg::PH_DECODE) begin
      ir_r   <= instr;
      kind_r <= kind_nxt;
    end
  end

  // ****************************************
  // file access
  // ****************************************
  assign req.addr = ir_r[6:0]; // RL4
  assign req.data = result_r;
  assign req.wen  = (phase_r_q == exec_pkg::PH_WRITE) && ir_r[`DEST_BIT] &&
                    (kind_r == exec_pkg::OPK_OR ||
                     kind_r == exec_pkg::OPK_COPY); // RL6

  file_mem #(.DEPTH(DEPTH)) u_file (
    .sys_clk  (sys_clk),
    .rdAddr   (req.addr),
    .wrEn     (req.wen),
    .wrAddr   (req.addr),
    .wrData   (req.data),
    .rdData_r (fileVal)
  );

  // ****************************************
  // process
  // ****************************************
  // operand combine
  always_comb begin
    unique case (kind_r)
      exec_pkg::OPK_OR:   result_nxt = accum_r | fileVal; // RL1
      exec_pkg::OPK_COPY: result_nxt = fileVal; // RL5
      exec_pkg::OPK_LIT:  result_nxt = ir_r[7:0]; // RL2
      exec_pkg::OPK_NONE: result_nxt = 8'h00;
    endcase
  end

  // result captured at process phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_r <= 8'h00;
    end else if (phase_r_q == exec_pkg::PH_PROCESS) begin
      result_r <= result_nxt;
    end
  end

  // ****************************************
  // write back
  // ****************************************
  // accumulator write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      accum_r <= `ACC_RESET;
    end else if (phase_r_q == exec_pkg::PH_WRITE) begin
      if (kind_r == exec_pkg::OPK_LIT) begin
        accum_r <= result_r; // RL2
      end else if ((kind_r == exec_pkg::OPK_OR ||
                    kind_r == exec_pkg::OPK_COPY) &&
                   !ir_r[`DEST_BIT]) begin
        accum_r <= result_r; // RL6
      end
    end
  end

  // zero flag, untouched by literal load
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      zero_r <= `ZERO_RESET;
    end else if (phase_r_q == exec_pkg::PH_WRITE &&
                 (kind_r == exec_pkg::OPK_OR ||
                  kind_r == exec_pkg::OPK_COPY)) begin
      zero_r <= (result_r == 8'h00); // RL7 RL8
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r   <= 2'h0;
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      done_r    <= (phase_r_q == exec_pkg::PH_WRITE);
      illegal_r <= (phase_r_q == exec_pkg::PH_WRITE) &&
                   (kind_r == exec_pkg::OPK_NONE);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // literal load must not disturb the zero flag
  AST_LIT_KEEPS_ZERO: assert property ( // RL3
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_WRITE && kind_r == exec_pkg::OPK_LIT)
    |=> $stable(zero_r)) else $error("literal load changed zero");
  // literal byte lands in the accumulator
  AST_LIT_LOADS: assert property ( // RL2
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_WRITE && kind_r == exec_pkg::OPK_LIT)
    |=> accum_r == $past(ir_r[7:0])) else $error("literal not loaded");
  // zero flag follows the result of or and copy
  AST_ZERO_FOLLOWS: assert property ( // RL7
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_WRITE && kind_r != exec_pkg::OPK_LIT &&
     kind_r != exec_pkg::OPK_NONE)
    |=> zero_r == ($past(result_r) == 8'h00)) else $error("zero wrong");
  // file destination leaves the accumulator alone
  AST_DEST_FILE: assert property ( // RL6
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_WRITE && ir_r[`DEST_BIT] &&
     kind_r != exec_pkg::OPK_LIT)
    |=> $stable(accum_r)) else $error("acc written for file dest");
  // copy to accumulator delivers the read value
  AST_DEST_ACC: assert property ( // RL5
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_WRITE && !ir_r[`DEST_BIT] &&
     kind_r == exec_pkg::OPK_COPY)
    |=> accum_r == $past(result_r)) else $error("copy to acc lost");
  // or combines accumulator and file operand
  AST_OR_RESULT: assert property ( // RL1
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_PROCESS && kind_r == exec_pkg::OPK_OR)
    |=> result_r == ($past(accum_r) | $past(fileVal)))
    else $error("or result wrong");
  // copy passes the file value through untouched
  AST_COPY_RESULT: assert property ( // RL4
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_PROCESS && kind_r == exec_pkg::OPK_COPY)
    |=> result_r == $past(fileVal)) else $error("copy altered value");
  // decode, read, process, write, then decode again
  AST_FOUR_PHASES: assert property ( // RL8
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q == exec_pkg::PH_DECODE) |=> ##2 phase_r_q == exec_pkg::PH_WRITE
    ##1 phase_r_q == exec_pkg::PH_DECODE) else $error("phase walk");

  // ****************************************
  // pulse and sequencing checks
  // ****************************************
  // illegal only ever rides on the done pulse
  AST_ILLEGAL_WITH_DONE: assert property ( // RL8
    @(posedge sys_clk) disable iff (sys_rst)
    illegal_r |-> done_r) else $error("illegal without done");
  // one done per four-cycle instruction
  AST_DONE_SPACING: assert property ( // RL8
    @(posedge sys_clk) disable iff (sys_rst)
    done_r |=> (!done_r) [*3] ##1 done_r) else $error("done spacing");
  // latched word ignores the input outside decode
  AST_WORD_HELD: assert property ( // RL8
    @(posedge sys_clk) disable iff (sys_rst)
    (phase_r_q != exec_pkg::PH_DECODE) |=> $stable(ir_r) && $stable(kind_r))
    else $error("word changed mid instruction");
  // visible phase code tracks the sequencer
  AST_PHASE_SHOWN: assert property ( // RL8
    @(posedge sys_clk) disable iff (sys_rst)
    phase_r == phase_r_q) else $error("phase output stale");

  // main scenarios
  COV_OR: cover property (@(posedge sys_clk)
    phase_r_q == exec_pkg::PH_WRITE && kind_r == exec_pkg::OPK_OR);
  COV_LIT: cover property (@(posedge sys_clk)
    phase_r_q == exec_pkg::PH_WRITE && kind_r == exec_pkg::OPK_LIT);
  COV_COPY_SELF: cover property (@(posedge sys_clk)
    req.wen && kind_r == exec_pkg::OPK_COPY);
  COV_ZERO_SET: cover property (@(posedge sys_clk)
    phase_r_q == exec_pkg::PH_WRITE && result_r == 8'h00 &&
    kind_r == exec_pkg::OPK_COPY);
  COV_ILLEGAL: cover property (@(posedge sys_clk)
    illegal_r);
endmodule // or_and_move_instruction_exec
`default_nettype wire
